//--- rtl/frame_device.sv
// Device end: serial frame parser with consecutive-offset data phase
`timescale 1ns/1ps
module frame_device
   import frame_pkg::*;
(
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_b_i,
   frame_link_if.device                  link,
   output logic                          wr_valid_o,
   output logic [frame_pkg::ADDR_W-1:0]  acc_addr_o,
   output logic [frame_pkg::BLOCK_W-1:0] acc_block_o,
   output frame_pkg::block_route_t       acc_route_o,
   output logic [7:0]                    wr_data_o,
   output logic                          rd_req_o,
   input  wire logic [7:0]               rd_data_i,
   output logic                          frame_end_o,
   output logic                          mode_err_o
);
   import frame_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_CTRL, ST_WDATA, ST_RDATA} phase_t;

   typedef struct packed {
      logic [2:0]  cs_s;
      logic [2:0]  ck_s;
      logic [1:0]  mo_s;
      phase_t      phase;
      logic [4:0]  cnt;
      logic [23:0] hdr;
      logic [7:0]  shin;
      logic [7:0]  shout;
      logic [15:0] addr;
      logic [4:0]  blk;
      logic        miso;
      logic        wr_v;
      logic [7:0]  wdat;
      logic        rreq;
      logic        rload;
      logic        fend;
      logic        merr;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic   cs_n, ck_rise, ck_fall, bit_in;

   // Sync stage 0 feeds only stage 1; edges come from stages 1 and 2
   assign cs_n    = st_r.cs_s[1];
   assign ck_rise = st_r.ck_s[1] & ~st_r.ck_s[2];
   assign ck_fall = ~st_r.ck_s[1] & st_r.ck_s[2];
   assign bit_in  = st_r.mo_s[1];

   always_comb begin
      st_nxt      = st_r;
      st_nxt.cs_s = {st_r.cs_s[1:0], link.chip_select_n};
      st_nxt.ck_s = {st_r.ck_s[1:0], link.sclk};
      st_nxt.mo_s = {st_r.mo_s[0], link.mosi};
      st_nxt.wr_v = 1'b0;
      st_nxt.rreq = 1'b0;
      st_nxt.rload = st_r.rreq;
      st_nxt.fend = 1'b0;
      if (cs_n) begin
         // Partial bytes are dropped; parser restarts at address phase
         if (st_r.phase != ST_IDLE) begin
            st_nxt.fend = 1'b1;
         end
         st_nxt.phase = ST_IDLE;
         st_nxt.cnt   = '0;
         st_nxt.miso  = 1'b0;
      end else begin
         case (st_r.phase)
            ST_IDLE: begin
               st_nxt.phase = ST_CTRL;
               st_nxt.cnt   = '0;
            end
            ST_CTRL: begin
               if (ck_rise) begin
                  // Header arrives address, block, flag, mode, MSB first
                  st_nxt.hdr = {st_r.hdr[22:0], bit_in};
                  st_nxt.cnt = st_r.cnt + 5'd1;
                  if (st_r.cnt == 5'(CTRL_BITS - 1)) begin
                     st_nxt.cnt  = '0;
                     st_nxt.addr = st_r.hdr[22:7];
                     st_nxt.blk  = st_r.hdr[6:2];
                     st_nxt.merr = ({st_r.hdr[0], bit_in} != MODE_VARIABLE);
                     if (st_r.hdr[1] == FLAG_WRITE) begin
                        st_nxt.phase = ST_WDATA;
                     end else begin
                        st_nxt.phase = ST_RDATA;
                        st_nxt.rreq  = 1'b1;
                     end
                  end
               end
            end
            ST_WDATA: begin
               if (ck_rise) begin
                  st_nxt.shin = {st_r.shin[6:0], bit_in};
                  st_nxt.cnt  = st_r.cnt + 5'd1;
                  if (st_r.cnt == 5'd7) begin
                     // Any byte count is fine; chip select alone ends it
                     st_nxt.cnt  = '0;
                     st_nxt.wdat = {st_r.shin[6:0], bit_in};
                     st_nxt.wr_v = 1'b1;
                  end
               end
               if (st_r.wr_v) begin
                  st_nxt.addr = st_r.addr + 16'h0001;
               end
            end
            ST_RDATA: begin
               // Data appears the cycle after the request, load shifter
               if (st_r.rload) begin
                  st_nxt.shout = rd_data_i;
               end
               // Drive only after a fall, so the bit stands at the next rise
               if (ck_fall) begin
                  st_nxt.miso  = st_r.shout[7];
                  st_nxt.shout = {st_r.shout[6:0], 1'b0};
                  st_nxt.cnt   = st_r.cnt + 5'd1;
                  if (st_r.cnt == 5'd7) begin
                     st_nxt.cnt  = '0;
                     st_nxt.addr = st_r.addr + 16'h0001;
                     st_nxt.rreq = 1'b1;
                  end
               end
            end
            default: st_nxt.phase = ST_IDLE;
         endcase
      end
   end

   // Single register bank for all state
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r       <= '0;
         st_r.cs_s  <= 3'h7;
         st_r.phase <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.miso   = st_r.miso;
   assign wr_valid_o  = st_r.wr_v;
   assign wr_data_o   = st_r.wdat;
   assign acc_addr_o  = st_r.addr;
   assign acc_block_o = st_r.blk;
   assign acc_route_o = route_of(st_r.blk);
   assign rd_req_o    = st_r.rreq;
   assign frame_end_o = st_r.fend;
   assign mode_err_o  = st_r.merr;
endmodule // frame_device

//--- rtl/frame_host.sv
// Host end: drives variable-length frames, clock made by a divider
`timescale 1ns/1ps
module frame_host
   import frame_pkg::*;
(
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_b_i,
   frame_link_if.host                    link,
   input  wire logic                     start_i,
   input  wire logic                     write_i,
   input  wire logic [frame_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [frame_pkg::BLOCK_W-1:0] block_i,
   input  wire logic [7:0]               tx_data_i,
   input  wire logic                     last_i,
   output logic                          busy_o,
   output logic                          byte_req_o,
   output logic                          rx_valid_o,
   output logic [7:0]                    rx_data_o
);
   import frame_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END} hphase_t;

   typedef struct packed {
      hphase_t     phase;
      logic [7:0]  div;
      logic        sclk;
      logic        csn;
      logic [23:0] sh;
      logic [4:0]  cnt;
      logic        hdr;
      logic        wr;
      logic        last;
      logic [1:0]  mi_s;
      logic [7:0]  rx;
      logic        rxv;
      logic        breq;
   } hstate_t;

   hstate_t st_r;
   hstate_t st_nxt;
   logic    tick;

   assign tick = (st_r.div == 8'(HALF_DIV - 1));

   always_comb begin
      st_nxt      = st_r;
      st_nxt.mi_s = {st_r.mi_s[0], link.miso};
      st_nxt.rxv  = 1'b0;
      st_nxt.breq = 1'b0;
      st_nxt.div  = (st_r.phase == H_IDLE || tick) ? 8'h00 : st_r.div + 8'h01;
      case (st_r.phase)
         H_IDLE: begin
            st_nxt.sclk = 1'b0;
            st_nxt.csn  = 1'b1;
            if (start_i) begin
               // Header: address, block, flag, variable mode code
               st_nxt.sh    = {addr_i, block_i, write_i, MODE_VARIABLE};
               st_nxt.csn   = 1'b0;
               st_nxt.cnt   = '0;
               st_nxt.hdr   = 1'b1;
               st_nxt.wr    = write_i;
               st_nxt.last  = 1'b0;
               st_nxt.phase = H_SHIFT;
            end
         end
         H_SHIFT: begin
            if (tick) begin
               st_nxt.sclk = ~st_r.sclk;
               if (st_r.sclk) begin
                  // Falling edge: advance MOSI so it settles before rise
                  st_nxt.sh  = {st_r.sh[22:0], 1'b0};
                  st_nxt.cnt = st_r.cnt + 5'd1;
                  if (!st_r.hdr && !st_r.wr) begin
                     // Bit on the wire at the rise has cleared the sync flops
                     st_nxt.rx = {st_r.rx[6:0], st_r.mi_s[1]};
                  end
                  if (st_r.cnt == (st_r.hdr ? 5'(CTRL_BITS - 1) : 5'd7)) begin
                     st_nxt.cnt  = '0;
                     st_nxt.hdr  = 1'b0;
                     st_nxt.breq = 1'b1;
                     if (!st_r.hdr && !st_r.wr) begin
                        st_nxt.rxv = 1'b1;
                     end
                     if (st_r.last) begin
                        st_nxt.phase = H_END;
                     end else begin
                        st_nxt.sh   = {tx_data_i, 16'h0000};
                        st_nxt.last = last_i;
                     end
                  end
               end
            end
         end
         H_END: begin
            if (tick) begin
               st_nxt.csn   = 1'b1;
               st_nxt.phase = H_IDLE;
            end
         end
         default: st_nxt.phase = H_IDLE;
      endcase
   end

   // Single register bank for all host state
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r       <= '0;
         st_r.csn   <= 1'b1;
         st_r.phase <= H_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.chip_select_n = st_r.csn;
   assign link.sclk          = st_r.sclk;
   assign link.mosi          = st_r.sh[23];
   assign busy_o             = (st_r.phase != H_IDLE);
   assign byte_req_o         = st_r.breq;
   assign rx_valid_o         = st_r.rxv;
   assign rx_data_o          = st_r.rx;
endmodule // frame_host

//--- rtl/frame_link_if.sv
// Link wires between the frame host and the frame device
`timescale 1ns/1ps
interface frame_link_if;
   logic chip_select_n;
   logic sclk;
   logic mosi;
   logic miso;
   modport host   (output chip_select_n, output sclk, output mosi, input miso);
   modport device (input chip_select_n, input sclk, input mosi, output miso);
endinterface

//--- rtl/frame_pkg.sv
// Shared constants and types for the variable-length serial frame link
// Summary of operation
// - Data phase any length, one byte upward
// - Host sends length mode field as 00
// - Write frame: read/write flag set to 1
// - Host lowers chip select before first bit
// - Host shifts MOSI on falling clock edge
// - Chip select rising ends the frame
// - Write bytes go to consecutive offsets
// - Read frame: read/write flag cleared to 0
// - Read returns data bits on MISO
// - Read bytes come from consecutive offsets
// - Order: address, block select, flag, mode, data
// - Block select 00000 routes to common registers
// - Codes 00110, 01111, 11101 route socket blocks
// - Data bytes travel most significant bit first
// - Length mode 00 selects variable length
package frame_pkg;
   localparam int ADDR_W          = 16;
   localparam int BLOCK_W         = 5;
   localparam int MODE_W          = 2;
   localparam int CTRL_BITS       = 24;
   localparam int BLOCK_LSB       = 3;
   localparam int FLAG_POS        = 2;
   localparam int MODE_LSB        = 0;
   localparam logic [1:0] MODE_VARIABLE = 2'h0;
   localparam logic       FLAG_READ     = 1'b0;
   localparam logic       FLAG_WRITE    = 1'b1;
   localparam logic [4:0] BLK_COMMON    = 5'h00;
   localparam logic [4:0] BLK_S1_TX     = 5'h06;
   localparam logic [4:0] BLK_S3_RX     = 5'h0F;
   localparam logic [4:0] BLK_S7_REG    = 5'h1D;
   localparam int SYS_PERIOD_NS   = 10;
   localparam int LINK_PERIOD_NS  = 80;
   localparam int HALF_DIV        = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
   typedef enum logic [2:0] {
      BLOCK_COMMON, BLOCK_S1_TX, BLOCK_S3_RX, BLOCK_S7_REG, BLOCK_OTHER
   } block_route_t;
   // Route decode used by the device end only
   function automatic block_route_t route_of(input logic [4:0] code);
      case (code)
         BLK_COMMON: route_of = BLOCK_COMMON;
         BLK_S1_TX:  route_of = BLOCK_S1_TX;
         BLK_S3_RX:  route_of = BLOCK_S3_RX;
         BLK_S7_REG: route_of = BLOCK_S7_REG;
         default:    route_of = BLOCK_OTHER;
      endcase
   endfunction
endpackage

//--- verification/frame_link_sva.sv
// Wire-level checks on the link between the frame host and the frame device
`timescale 1ns/1ps
module frame_link_sva (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso
);
   logic       sclk_r;
   logic [7:0] rise_cnt_r;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Rising link clock edges within the frame; cleared while deselected
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_r     <= 1'b0;
         rise_cnt_r <= 8'h00;
      end else begin
         sclk_r <= sclk;
         if (chip_select_n)
            rise_cnt_r <= 8'h00;
         else if (sclk && !sclk_r)
            rise_cnt_r <= rise_cnt_r + 8'h01;
      end
   end
   property p_sclk_idle; chip_select_n |-> !sclk; endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("link clock high while deselected");
   property p_cs_first; $fell(chip_select_n) |-> (!sclk)[*3]; endproperty
   a_cs_first: assert property (p_cs_first) else $error("clock edge too soon after select");
   property p_mosi_fall; !chip_select_n && $changed(mosi) |-> !sclk; endproperty
   a_mosi_fall: assert property (p_mosi_fall) else $error("mosi moved while clock high");
   property p_sclk_half; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
   a_sclk_half: assert property (p_sclk_half) else $error("link clock high phase wrong");
   property p_miso_rise; !chip_select_n && $rose(sclk) |-> $stable(miso); endproperty
   a_miso_rise: assert property (p_miso_rise) else $error("miso moved at rising edge");
   property p_miso_low; !chip_select_n && $changed(miso) |-> !sclk; endproperty
   a_miso_low: assert property (p_miso_low) else $error("miso moved while clock high");
   property p_mode_zero;
      $rose(sclk) && !chip_select_n && (rise_cnt_r == 8'h16 || rise_cnt_r == 8'h17) |-> !mosi;
   endproperty
   a_mode_zero: assert property (p_mode_zero) else $error("length mode bit not zero");
   property p_frame_len;
      $rose(chip_select_n) |-> rise_cnt_r >= 8'h20 && rise_cnt_r[2:0] == 3'h0;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame not header plus whole bytes");
   property p_cs_gap; $rose(chip_select_n) |-> chip_select_n[*3]; endproperty
   a_cs_gap: assert property (p_cs_gap) else $error("deselect gap too short");
endmodule // frame_link_sva

//--- verification/spi_variable_length_frame_port_tb.sv
// Self-checking bench joining the frame host and the frame device
`timescale 1ns/1ps
module spi_variable_length_frame_port_tb;
   import frame_pkg::*;
   logic         sys_clk_i, rst_b_i, start_i, write_i, last_i, busy, byte_req, rx_valid;
   logic         wr_valid, rd_req, frame_end, mode_err;
   logic [15:0]  addr_i, acc_addr;
   logic [4:0]   block_i, acc_block;
   logic [7:0]   tx_data_i, rd_data_i, rx_data, wr_data;
   logic [7:0]   txb [8];
   logic [15:0]  wq_a [$];
   logic [7:0]   wq_d [$];
   logic [7:0]   rxq [$];
   logic [4:0]   wq_b [$];
   block_route_t acc_route, rd_route;
   block_route_t wq_r [$];
   int           n_fail, samples_checked, n_end;
   frame_link_if link ();
   frame_host frame_host_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(link),
      .start_i(start_i), .write_i(write_i), .addr_i(addr_i), .block_i(block_i),
      .tx_data_i(tx_data_i), .last_i(last_i), .busy_o(busy), .byte_req_o(byte_req),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data));
   frame_device frame_device_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(link),
      .wr_valid_o(wr_valid), .acc_addr_o(acc_addr), .acc_block_o(acc_block),
      .acc_route_o(acc_route), .wr_data_o(wr_data), .rd_req_o(rd_req), .rd_data_i(rd_data_i),
      .frame_end_o(frame_end), .mode_err_o(mode_err));
   frame_link_sva frame_link_sva_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .chip_select_n(link.chip_select_n), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso));
   // Record device accesses; answer reads from an address-derived pattern
   always @(posedge sys_clk_i) begin
      if (wr_valid === 1'b1) begin
         wq_a.push_back(acc_addr);
         wq_b.push_back(acc_block);
         wq_d.push_back(wr_data);
         wq_r.push_back(acc_route);
      end
      if (rd_req === 1'b1) begin
         rd_data_i <= #1 acc_addr[7:0] ^ 8'hA5;
         rd_route = acc_route;
      end
      if (rx_valid === 1'b1)
         rxq.push_back(rx_data);
      if (frame_end === 1'b1)
         n_end++;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_route(input block_route_t got, input block_route_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: route %0d expected %0d", $time, got, exp);
      end
   endtask
   // One whole frame; the next byte is offered at each byte request
   task automatic frame(input logic w, input logic [15:0] a, input logic [4:0] b,
                        input block_route_t r, input int n);
      int          i;
      int          e;
      logic [15:0] ea;
      i = 0;
      e = n_end;
      wq_a = {};
      wq_b = {};
      wq_d = {};
      wq_r = {};
      rxq = {};
      @(posedge sys_clk_i);
      #1;
      start_i = 1'b1;
      write_i = w;
      addr_i = a;
      block_i = b;
      tx_data_i = txb[0];
      last_i = (n == 1);
      @(posedge sys_clk_i);
      #1;
      start_i = 1'b0;
      repeat (4000) begin
         if (busy !== 1'b1)
            break;
         if (byte_req === 1'b1) begin
            i++;
            tx_data_i = txb[i % 8];
            last_i = (i >= n - 1);
         end
         @(posedge sys_clk_i);
         #1;
      end
      // Bounded wait for the device to see the deselect
      repeat (40) if (n_end == e) @(posedge sys_clk_i);
      chk(16'(n_end - e), 16'h0001);
      chk(16'(mode_err), 16'h0000);
      chk(16'(wq_a.size()), w ? 16'(n) : 16'h0000);
      chk(16'(rxq.size()), w ? 16'h0000 : 16'(n));
      for (i = 0; i < wq_a.size(); i++) begin
         chk(wq_a[i], a + 16'(i));
         chk({11'h000, wq_b[i]}, {11'h000, b});
         chk({8'h00, wq_d[i]}, {8'h00, txb[i]});
         chk_route(wq_r[i], r);
      end
      for (i = 0; i < rxq.size(); i++) begin
         ea = a + 16'(i);
         chk({8'h00, rxq[i]}, {8'h00, ea[7:0] ^ 8'hA5});
      end
      if (!w)
         chk_route(rd_route, r);
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Cut a hang short well past the expected two thousand or so cycles
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      {rst_b_i, start_i, write_i, last_i, addr_i, block_i, tx_data_i} = '0;
      {n_fail, samples_checked, n_end} = '0;
      repeat (6) @(posedge sys_clk_i);
      #1;
      rst_b_i = 1'b1;
      txb = '{8'hAA, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
      frame(1'b1, 16'h0018, BLK_COMMON, BLOCK_COMMON, 1);
      txb[0] = 8'h11;
      frame(1'b1, 16'h0040, BLK_S1_TX, BLOCK_S1_TX, 5);
      frame(1'b0, 16'h0003, BLK_S7_REG, BLOCK_S7_REG, 1);
      frame(1'b0, 16'h0100, BLK_S3_RX, BLOCK_S3_RX, 5);
      frame(1'b1, 16'hFFFF, 5'h1F, BLOCK_OTHER, 2);
      report_and_stop();
   end
endmodule // spi_variable_length_frame_port_tb
